// >>> hdl/flash_seq_pkg.sv
// Shared constants and carriers for the serial NAND program and erase sequencer
package flash_seq_pkg;

	// Command opcodes
	localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;
	localparam logic [7:0] OP_LOAD           = 8'h02;
	localparam logic [7:0] OP_LOAD_RANDOM    = 8'h84;
	localparam logic [7:0] OP_LOAD_X4        = 8'h32;
	localparam logic [7:0] OP_LOAD_RANDOM_X4 = 8'h34;
	localparam logic [7:0] OP_EXECUTE        = 8'h10;
	localparam logic [7:0] OP_ERASE          = 8'hD8;
	localparam logic [7:0] OP_GET_FEATURE    = 8'h0F;
	localparam logic [7:0] OP_SET_FEATURE    = 8'h1F;
	localparam logic [7:0] OP_RESET          = 8'hFF;

	// Feature addresses
	localparam logic [7:0] FEAT_LOCK   = 8'hA0;
	localparam logic [7:0] FEAT_CONFIG = 8'hB0;
	localparam logic [7:0] FEAT_STATUS = 8'hC0;
	localparam logic [7:0] FEAT_DIE    = 8'hD0;

	// Block lock fields
	localparam int LOCK_GUARD_BIT   = 7;
	localparam int LOCK_RANGE_LSB   = 3;
	localparam int LOCK_BOTTOM_BIT  = 2;
	localparam int LOCK_PIN_DIS_BIT = 1;
	localparam logic [7:0] LOCK_RESET     = 8'h7C;
	localparam logic [7:0] LOCK_WMASK     = 8'hFE;
	localparam logic [7:0] LOCK_HELD_MASK = 8'hFC;

	// Configuration fields
	localparam int CFG_FREEZE_BIT = 5;
	localparam logic [7:0] CFG_RESET       = 8'h00;
	localparam logic [7:0] CFG_WMASK       = 8'hF2;
	localparam logic [7:0] CFG_SELECT_MASK = 8'hC2;

	// Die choice fields
	localparam logic [7:0] DIE_RESET = 8'h00;
	localparam logic [7:0] DIE_WMASK = 8'h40;

	// Status fields
	localparam int STAT_PFAIL_BIT = 3;
	localparam int STAT_EFAIL_BIT = 2;
	localparam int STAT_LATCH_BIT = 1;
	localparam int STAT_BUSY_BIT  = 0;

	// Geometry
	localparam int CACHE_BYTES     = 2176;
	localparam int COL_W           = 12;
	localparam int ROW_W           = 24;
	localparam int BLOCK_LSB       = 6;
	localparam int BLOCK_W         = 11;
	localparam int BLOCK_TOTAL     = 2048;
	localparam int PROTECT_RANGE_MAX = 10;
	localparam logic [7:0] CACHE_FILL = 8'hFF;
	localparam logic [12:0] CACHE_LAST = 13'h087F;

	// Timing
	localparam int CLK_MHZ                = 125;
	localparam int PROGRAM_BUSY_TIME_NS   = 200000;
	localparam int ERASE_BUSY_TIME_NS     = 2000000;
	localparam int PROGRAM_BUSY_CYCLES    = PROGRAM_BUSY_TIME_NS * CLK_MHZ / 1000;
	localparam int ERASE_BUSY_CYCLES      = ERASE_BUSY_TIME_NS * CLK_MHZ / 1000;

	// Array write port
	typedef struct packed {
		logic             we;
		logic [ROW_W-1:0] row;
		logic [COL_W-1:0] col;
		logic [7:0]       data;
	} array_write_t;

	// Feature register snapshot
	typedef struct packed {
		logic [7:0] lock;
		logic [7:0] cfg;
		logic [7:0] status;
		logic [7:0] die;
	} feature_set_t;

	// Operation states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_COPY  = 2'b01,
		ST_PROG  = 2'b11,
		ST_ERASE = 2'b10
	} op_state_t;

endpackage : flash_seq_pkg

// >>> hdl/sync_stages.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
module sync_stages #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// Level in and out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule : sync_stages

// >>> hdl/cache_buffer.sv
// Page cache with one-cycle blank fill
`timescale 1ns/1ps
module cache_buffer (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Write side
	input  wire logic        clear,
	input  wire logic        wr_en,
	input  wire logic [11:0] wr_addr,
	input  wire logic [7:0]  wr_data,
	// Read side
	input  wire logic [11:0] rd_addr,
	output logic      [7:0]  rd_data
);
	logic [7:0]                           mem [flash_seq_pkg::CACHE_BYTES];
	logic [flash_seq_pkg::CACHE_BYTES-1:0] written_reg;

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Bytes not written since a clear read as blank
	always_ff @(posedge clk) begin
		if (srst) begin
			written_reg <= '0;
		end else begin
			if (clear) begin
				written_reg <= '0;
			end
			if (wr_en) begin
				written_reg[wr_addr] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rd_data <= flash_seq_pkg::CACHE_FILL;
		end else if (written_reg[rd_addr]) begin
			rd_data <= mem[rd_addr];
		end else begin
			rd_data <= flash_seq_pkg::CACHE_FILL;
		end
	end
endmodule : cache_buffer

// >>> hdl/flash_sequencer.sv
// Serial NAND command sequencer: loads, program, erase and feature registers
`timescale 1ns/1ps
module flash_sequencer #(
	parameter int PROGRAM_CYCLES = flash_seq_pkg::PROGRAM_BUSY_CYCLES,
	parameter int ERASE_CYCLES   = flash_seq_pkg::ERASE_BUSY_CYCLES
) (
	// System clock and reset
	input  wire logic                          clk,
	input  wire logic                          srst,
	// Serial link
	input  wire logic                          sclk,
	input  wire logic                          cs_n,
	input  wire logic [3:0]                    dq_in,
	output logic      [3:0]                    dq_out,
	output logic      [3:0]                    dq_oe,
	input  wire logic                          wp_n,
	// Array side
	output flash_seq_pkg::array_write_t        array_wr,
	output logic                               array_erase,
	output logic      [flash_seq_pkg::BLOCK_W-1:0] array_erase_block
);
	// Link domain state
	logic [7:0]                   link_shift_reg;
	logic [7:0]                   link_byte_reg;
	logic [7:0]                   link_op_reg;
	logic [7:0]                   link_faddr_reg;
	logic [7:0]                   link_out_reg;
	logic [3:0]                   link_bits_reg;
	logic [1:0]                   link_idx_reg;
	logic                         link_quad_reg;
	logic                         link_read_reg;
	logic                         link_toggle_reg;
	logic [7:0]                   link_shift_next;
	logic [3:0]                   link_bits_next;
	logic                         link_done;
	logic [7:0]                   link_sel;
	// System domain state
	flash_seq_pkg::feature_set_t  feat_snap_reg;
	flash_seq_pkg::op_state_t     state_reg;
	logic [7:0]                   lock_reg;
	logic [7:0]                   cfg_reg;
	logic [7:0]                   die_reg;
	logic                         wel_reg;
	logic                         pfail_reg;
	logic                         efail_reg;
	logic [7:0]                   op_reg;
	logic [7:0]                   faddr_reg;
	logic [1:0]                   idx_reg;
	logic [23:0]                  row_reg;
	logic [12:0]                  col_reg;
	logic [31:0]                  timer_reg;
	logic [11:0]                  walk_reg;
	logic [11:0]                  walk_d_reg;
	logic                         copy_d_reg;
	logic                         seen_reg;
	logic                         toggle_sync;
	logic                         cs_sync;
	logic                         wp_sync;
	logic                         byte_evt;
	logic [7:0]                   evt_byte;
	logic [7:0]                   status_now;
	logic [23:0]                  row_full;
	logic                         is_load;
	logic                         is_x4_op;
	logic                         busy;
	logic                         cache_clear;
	logic                         cache_wr;
	logic [7:0]                   cache_rd_data;
	logic [7:0]                   lock_mask;
	logic                         target_locked;

	// Link side: bit assembly on rising sclk
	always_comb begin
		link_shift_next = link_quad_reg ? {link_shift_reg[3:0], dq_in} : {link_shift_reg[6:0], dq_in[0]};
		link_bits_next  = link_bits_reg + (link_quad_reg ? 4'h4 : 4'h1);
		link_done       = (link_bits_next == 4'h8);
		is_x4_op        = (link_op_reg == flash_seq_pkg::OP_LOAD_X4) ||
		                  (link_op_reg == flash_seq_pkg::OP_LOAD_RANDOM_X4);
		unique case (link_shift_next)
			flash_seq_pkg::FEAT_LOCK:   link_sel = feat_snap_reg.lock;
			flash_seq_pkg::FEAT_CONFIG: link_sel = feat_snap_reg.cfg;
			flash_seq_pkg::FEAT_STATUS: link_sel = feat_snap_reg.status;
			flash_seq_pkg::FEAT_DIE:    link_sel = feat_snap_reg.die;
			default:                    link_sel = 8'h00;
		endcase
	end

	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			link_shift_reg <= 8'h00;
			link_op_reg    <= 8'h00;
			link_faddr_reg <= 8'h00;
			link_out_reg   <= 8'h00;
			link_bits_reg  <= 4'h0;
			link_idx_reg   <= 2'h0;
			link_quad_reg  <= 1'b0;
			link_read_reg  <= 1'b0;
		end else begin
			link_shift_reg <= link_shift_next;
			link_bits_reg  <= link_done ? 4'h0 : link_bits_next;
			if (link_read_reg) begin
				link_out_reg <= {link_out_reg[6:0], 1'b0};
			end
			if (link_done) begin
				if (link_idx_reg != 2'h3) begin
					link_idx_reg <= link_idx_reg + 2'h1;
				end
				if (link_idx_reg == 2'h0) begin
					link_op_reg <= link_shift_next;
				end
				if (link_idx_reg == 2'h2 && is_x4_op) begin
					link_quad_reg <= 1'b1;
				end
				if (link_idx_reg == 2'h1 && link_op_reg == flash_seq_pkg::OP_GET_FEATURE) begin
					link_faddr_reg <= link_shift_next;
					link_out_reg   <= link_sel;
					link_read_reg  <= 1'b1;
				end else if (link_read_reg) begin
					link_out_reg <= link_faddr_reg == flash_seq_pkg::FEAT_LOCK   ? feat_snap_reg.lock :
					                link_faddr_reg == flash_seq_pkg::FEAT_CONFIG ? feat_snap_reg.cfg :
					                link_faddr_reg == flash_seq_pkg::FEAT_STATUS ? feat_snap_reg.status :
					                link_faddr_reg == flash_seq_pkg::FEAT_DIE    ? feat_snap_reg.die : 8'h00;
				end
			end
		end
	end

	// Byte event toggle, kept across frames
	// Last byte is held past chip select so the system side can still take it
	always_ff @(posedge sclk or posedge srst) begin
		if (srst) begin
			link_toggle_reg <= 1'b0;
			link_byte_reg   <= 8'h00;
		end else if (!cs_n && link_done) begin
			link_toggle_reg <= ~link_toggle_reg;
			link_byte_reg   <= link_shift_next;
		end
	end

	// Read data shifted out on falling sclk
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			dq_out <= 4'h0;
			dq_oe  <= 4'h0;
		end else begin
			dq_out <= {2'b00, link_out_reg[7], 1'b0};
			dq_oe  <= {2'b00, link_read_reg, 1'b0};
		end
	end

	// Crossings into the system clock
	sync_stages #(.W(3)) u_sync (
		.clk  (clk),
		.srst (srst),
		.d    ({link_toggle_reg, cs_n, wp_n}),
		.q    ({toggle_sync, cs_sync, wp_sync})
	);

	assign byte_evt = (toggle_sync != seen_reg);
	assign evt_byte = link_byte_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			seen_reg <= 1'b0;
		end else begin
			seen_reg <= toggle_sync;
		end
	end

	// Snapshot frozen while a frame is open
	always_ff @(posedge clk) begin
		if (srst) begin
			feat_snap_reg <= '0;
		end else if (cs_sync && !byte_evt) begin
			feat_snap_reg <= '{lock: lock_reg, cfg: cfg_reg, status: status_now, die: die_reg};
		end
	end

	always_comb begin
		status_now = 8'h00;
		status_now[flash_seq_pkg::STAT_PFAIL_BIT] = pfail_reg;
		status_now[flash_seq_pkg::STAT_EFAIL_BIT] = efail_reg;
		status_now[flash_seq_pkg::STAT_LATCH_BIT] = wel_reg;
		status_now[flash_seq_pkg::STAT_BUSY_BIT]  = busy;
	end

	assign busy     = (state_reg != flash_seq_pkg::ST_IDLE);
	assign row_full = {row_reg[15:0], evt_byte};
	assign is_load  = (op_reg == flash_seq_pkg::OP_LOAD) || (op_reg == flash_seq_pkg::OP_LOAD_RANDOM) ||
	                  (op_reg == flash_seq_pkg::OP_LOAD_X4) || (op_reg == flash_seq_pkg::OP_LOAD_RANDOM_X4);

	// range decode of the lock register
	always_comb begin
		logic [3:0]  rng;
		logic [11:0] span;
		logic [11:0] blk;
		rng  = lock_reg[flash_seq_pkg::LOCK_RANGE_LSB +: 4];
		span = 12'h001 << rng;
		blk  = {1'b0, row_full[flash_seq_pkg::BLOCK_LSB +: flash_seq_pkg::BLOCK_W]};
		if (rng == 4'h0) begin
			target_locked = 1'b0;
		end else if (rng > 4'(flash_seq_pkg::PROTECT_RANGE_MAX)) begin
			target_locked = 1'b1;
		end else if (lock_reg[flash_seq_pkg::LOCK_BOTTOM_BIT]) begin
			target_locked = (blk < span);
		end else begin
			target_locked = (blk >= 12'(flash_seq_pkg::BLOCK_TOTAL) - span);
		end
	end

	always_comb begin
		lock_mask = flash_seq_pkg::LOCK_WMASK;
		if ((!lock_reg[flash_seq_pkg::LOCK_PIN_DIS_BIT] && lock_reg[flash_seq_pkg::LOCK_GUARD_BIT] && !wp_sync) ||
		    cfg_reg[flash_seq_pkg::CFG_FREEZE_BIT]) begin
			lock_mask = lock_mask & ~flash_seq_pkg::LOCK_HELD_MASK;
		end
	end

	// Frame byte index and address capture
	always_ff @(posedge clk) begin
		if (srst) begin
			idx_reg   <= 2'h0;
			op_reg    <= 8'h00;
			faddr_reg <= 8'h00;
			row_reg   <= 24'h000000;
		end else if (byte_evt) begin
			if (idx_reg != 2'h3) begin
				idx_reg <= idx_reg + 2'h1;
			end
			if (idx_reg == 2'h0) begin
				op_reg <= evt_byte;
			end
			if (idx_reg == 2'h1) begin
				faddr_reg <= evt_byte;
			end
			if (idx_reg != 2'h0 && idx_reg != 2'h3) begin
				row_reg <= row_full;
			end
		end else if (cs_sync) begin
			idx_reg <= 2'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			col_reg <= 13'h0000;
		end else if (byte_evt && is_load) begin
			if (idx_reg == 2'h2) begin
				col_reg <= {1'b0, row_reg[3:0], evt_byte};
			end else if (idx_reg == 2'h3 && col_reg <= flash_seq_pkg::CACHE_LAST) begin
				col_reg <= col_reg + 13'h0001;
			end
		end
	end

	assign cache_clear = byte_evt && idx_reg == 2'h0 && !busy &&
	                     (evt_byte == flash_seq_pkg::OP_LOAD || evt_byte == flash_seq_pkg::OP_LOAD_X4);
	assign cache_wr    = byte_evt && idx_reg == 2'h3 && is_load && !busy && col_reg <= flash_seq_pkg::CACHE_LAST;

	cache_buffer u_cache (
		.clk     (clk),
		.srst    (srst),
		.clear   (cache_clear),
		.wr_en   (cache_wr),
		.wr_addr (col_reg[11:0]),
		.wr_data (evt_byte),
		.rd_addr (walk_reg),
		.rd_data (cache_rd_data)
	);

	// guard and pin disable start at zero
	always_ff @(posedge clk) begin
		if (srst) begin
			lock_reg <= flash_seq_pkg::LOCK_RESET;
			cfg_reg  <= flash_seq_pkg::CFG_RESET;
			die_reg  <= flash_seq_pkg::DIE_RESET;
		end else if (byte_evt && !busy) begin
			if (idx_reg == 2'h0 && evt_byte == flash_seq_pkg::OP_RESET) begin
				cfg_reg <= cfg_reg & ~flash_seq_pkg::CFG_SELECT_MASK;
			end
			if (idx_reg == 2'h2 && op_reg == flash_seq_pkg::OP_SET_FEATURE) begin
				unique case (faddr_reg)
					flash_seq_pkg::FEAT_LOCK: begin
						lock_reg <= (lock_reg & ~lock_mask) | (evt_byte & lock_mask);
					end
					flash_seq_pkg::FEAT_CONFIG: begin
						cfg_reg <= (evt_byte & flash_seq_pkg::CFG_WMASK) |
						           {2'b00, cfg_reg[flash_seq_pkg::CFG_FREEZE_BIT], 5'b00000};
					end
					flash_seq_pkg::FEAT_DIE: begin
						die_reg <= evt_byte & flash_seq_pkg::DIE_WMASK;
					end
					default: begin
						lock_reg <= lock_reg;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wel_reg <= 1'b0;
		end else if (byte_evt && !busy && idx_reg == 2'h0 && evt_byte == flash_seq_pkg::OP_WRITE_ENABLE) begin
			wel_reg <= 1'b1;
		end else if (byte_evt && !busy && idx_reg == 2'h0 && evt_byte == flash_seq_pkg::OP_WRITE_DISABLE) begin
			wel_reg <= 1'b0;
		end else if (byte_evt && !busy && idx_reg == 2'h3 && wel_reg && target_locked &&
		             (op_reg == flash_seq_pkg::OP_EXECUTE || op_reg == flash_seq_pkg::OP_ERASE)) begin
			wel_reg <= 1'b0;
		end else if (busy && timer_reg == 32'h0 && state_reg != flash_seq_pkg::ST_COPY) begin
			wel_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= flash_seq_pkg::ST_IDLE;
			timer_reg <= 32'h0;
			walk_reg  <= 12'h000;
			pfail_reg <= 1'b0;
			efail_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				flash_seq_pkg::ST_IDLE: begin
					walk_reg <= 12'h000;
					if (byte_evt && idx_reg == 2'h3 && wel_reg && op_reg == flash_seq_pkg::OP_EXECUTE) begin
						pfail_reg <= target_locked;
						if (!target_locked) begin
							state_reg <= flash_seq_pkg::ST_COPY;
							timer_reg <= 32'(PROGRAM_CYCLES - 1);
						end
					end else if (byte_evt && idx_reg == 2'h3 && wel_reg && op_reg == flash_seq_pkg::OP_ERASE) begin
						efail_reg <= target_locked;
						if (!target_locked) begin
							state_reg <= flash_seq_pkg::ST_ERASE;
							timer_reg <= 32'(ERASE_CYCLES - 1);
						end
					end
				end
				flash_seq_pkg::ST_COPY: begin
					timer_reg <= timer_reg - 32'h1;
					walk_reg  <= walk_reg + 12'h001;
					if (walk_reg == flash_seq_pkg::CACHE_LAST[11:0]) begin
						state_reg <= flash_seq_pkg::ST_PROG;
					end
				end
				flash_seq_pkg::ST_PROG: begin
					timer_reg <= timer_reg - 32'h1;
					if (timer_reg == 32'h0) begin
						state_reg <= flash_seq_pkg::ST_IDLE;
					end
				end
				flash_seq_pkg::ST_ERASE: begin
					timer_reg <= timer_reg - 32'h1;
					if (timer_reg == 32'h0) begin
						state_reg <= flash_seq_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// Row latched at address registration
	always_ff @(posedge clk) begin
		if (srst) begin
			array_wr          <= '0;
			array_erase       <= 1'b0;
			array_erase_block <= '0;
			copy_d_reg        <= 1'b0;
			walk_d_reg        <= 12'h000;
		end else begin
			copy_d_reg   <= (state_reg == flash_seq_pkg::ST_COPY);
			walk_d_reg   <= walk_reg;
			array_wr.we  <= copy_d_reg;
			array_wr.col <= walk_d_reg;
			array_wr.data <= cache_rd_data;
			array_erase  <= 1'b0;
			if (state_reg == flash_seq_pkg::ST_IDLE && byte_evt && idx_reg == 2'h3 && wel_reg && !target_locked &&
			    (op_reg == flash_seq_pkg::OP_EXECUTE || op_reg == flash_seq_pkg::OP_ERASE)) begin
				array_wr.row <= row_full;
				if (op_reg == flash_seq_pkg::OP_ERASE) begin
					array_erase       <= 1'b1;
					array_erase_block <= row_full[flash_seq_pkg::BLOCK_LSB +: flash_seq_pkg::BLOCK_W];
				end
			end
		end
	end
endmodule : flash_sequencer

// >>> verification/flash_seq_asserts.sv
// Port assertions for the flash sequencer
`timescale 1ns/1ps
module flash_seq_asserts (
	// Clock and reset
	input wire logic                            clk,
	input wire logic                            srst,
	// Watched ports
	input wire logic                            cs_n,
	input wire logic [3:0]                      dq_oe,
	input wire flash_seq_pkg::array_write_t     array_wr,
	input wire logic                            array_erase,
	input wire logic [flash_seq_pkg::BLOCK_W-1:0] array_erase_block
);
	logic [11:0] col_reg;
	logic [23:0] row_reg;
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	// Last written array place
	always_ff @(posedge clk) begin
		if (srst) begin
			col_reg <= 12'h000;
			row_reg <= 24'h000000;
		end else if (array_wr.we) begin
			col_reg <= array_wr.col;
			row_reg <= array_wr.row;
		end
	end
	a_oe_idle_off: assert property (cs_n |-> dq_oe == 4'h0)
		else $error("output enable set outside a frame");
	a_oe_one_line: assert property (dq_oe[3:2] == 2'h0 && dq_oe[0] == 1'b0)
		else $error("output enable on a wrong line");
	a_erase_one_pulse: assert property (array_erase |=> !array_erase)
		else $error("erase pulse too long");
	a_erase_quiet_array: assert property (array_erase |=> !array_wr.we [*8])
		else $error("array write during erase");
	a_erase_block_hold: assert property ($changed(array_erase_block) |-> array_erase || $past(array_erase))
		else $error("erase block moved without erase");
	a_write_col_range: assert property (array_wr.we |-> array_wr.col <= 12'h87F)
		else $error("array column beyond cache");
	a_write_col_step: assert property (array_wr.we && array_wr.col != 12'h000 |-> array_wr.col == col_reg + 12'h001)
		else $error("array column skipped");
	a_write_row_hold: assert property (array_wr.we && array_wr.col != 12'h000 |-> array_wr.row == row_reg)
		else $error("array row changed in a page");
endmodule : flash_seq_asserts
bind flash_sequencer flash_seq_asserts chk (.clk, .srst, .cs_n, .dq_oe, .array_wr, .array_erase, .array_erase_block);

// >>> verification/spi_host_model.sv
// Behavioural host on the serial link, mode 0
`timescale 1ns/1ps
module spi_host_model (
	// Link
	output logic            sclk,
	output logic            cs_n,
	output logic      [3:0] dq_in,
	input  wire logic [3:0] dq_out
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		dq_in = 4'h5;
	end
	// One framed command; x4 sends data nibbles after three bytes
	task automatic frame(input logic [7:0] b[$], input bit x4, output logic [7:0] rd);
		int n;
		#7 cs_n = 1'b0;
		for (int i = 0; i < b.size(); i++) begin
			n = (x4 && i > 2) ? 2 : 8;
			for (int k = n - 1; k >= 0; k--) begin
				dq_in = (n == 2) ? b[i][4*k+:4] : {~dq_in[3:1], b[i][k]};
				#15 sclk = 1'b1;
				rd = {rd[6:0], dq_out[1]};
				#15 sclk = 1'b0;
			end
		end
		#7 cs_n = 1'b1;
		dq_in = ~dq_in;
		#120;
	endtask : frame
endmodule : spi_host_model

// >>> verification/nand_tb_top.sv
// Self-checking bench for the flash sequencer
`timescale 1ns/1ps
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin n_fail++; $display("Error %s exp %h got %h", nm, e, s); end end
module serial_nand_program_erase_features_tb_top;
	logic        clk;
	logic        srst;
	logic        wp_n;
	logic        wp_val;
	logic        sclk;
	logic        cs_n;
	logic [3:0]  dq_in;
	logic [3:0]  dq_out;
	logic [3:0]  dq_oe;
	logic        erase;
	logic [10:0] blk;
	logic [7:0]  rd;
	logic [7:0]  cache [2176];
	logic [7:0]  got [2176];
	logic [23:0] wrow;
	logic [23:0] prow;
	logic [31:0] lfsr;
	int          n_fail;
	int          check_count;
	int          n_we;
	int          n_ers;
	int          cyc;
	int          c;
	flash_seq_pkg::array_write_t awr;
	flash_sequencer #(.PROGRAM_CYCLES(3000), .ERASE_CYCLES(50)) DUT (.clk, .srst, .sclk, .cs_n, .dq_in, .dq_out,
		.dq_oe, .wp_n, .array_wr(awr), .array_erase(erase), .array_erase_block(blk));
	spi_host_model host (.sclk, .cs_n, .dq_in, .dq_out);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		wp_n <= wp_val;
		if (awr.we) begin
			got[awr.col] <= awr.data;
			wrow <= awr.row;
			n_we <= n_we + 1;
		end
		if (erase)
			n_ers <= n_ers + 1;
		if (cyc == 40000) begin
			n_fail++;
			give_verdict();
		end
	end
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : step
	task automatic fr(input logic [7:0] b[$]);
		host.frame(b, 1'b0, rd);
	endtask : fr
	task automatic feat(input logic [7:0] a, input logic [7:0] e, input string nm);
		fr('{8'h0F, a, 8'h00});
		`CHK(nm, e, rd)
	endtask : feat
	task automatic set(input logic [7:0] a, input logic [7:0] d);
		fr('{8'h1F, a, d});
	endtask : set
	task automatic poll(input logic ob, input logic [7:0] st);
		fr('{8'h0F, 8'hC0, 8'h00});
		`CHK("busy", ob, rd[0])
		for (int i = 0; i < 60 && rd[0] !== 1'b0; i++)
			fr('{8'h0F, 8'hC0, 8'h00});
		`CHK("status", st, rd)
	endtask : poll
	task automatic exe(input logic [7:0] op, input logic [23:0] r, input logic we, input logic ob, input logic [7:0] st);
		n_we = 0;
		n_ers = 0;
		prow = r;
		foreach (got[i])
			got[i] = ~cache[i];
		if (we)
			fr('{8'h06});
		fr('{op, r[23:16], r[15:8], r[7:0]});
		poll(ob, st);
	endtask : exe
	task automatic load(input logic [7:0] op, input int col, input int n);
		logic [7:0] q[$];
		q = '{op, 8'(col >> 8), 8'(col)};
		if (op[1])
			foreach (cache[i])
				cache[i] = 8'hFF;
		for (int i = 0; i < n; i++) begin
			lfsr = step(lfsr);
			q.push_back(lfsr[7:0]);
			if (col + i < 2176)
				cache[col + i] = lfsr[7:0];
		end
		host.frame(q, op[5], rd);
	endtask : load
	task automatic chk_cache;
		`CHK("writes", 2176, n_we)
		`CHK("row", prow, wrow)
		foreach (cache[i]) `CHK("byte", cache[i], got[i])
	endtask : chk_cache
	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	initial begin
		srst = 1'b1;
		wp_val = 1'b1;
		lfsr = 32'h7D29;
		{n_fail, check_count, n_we, n_ers, cyc} = '0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		feat(8'hA0, 8'h7C, "lock");
		feat(8'hB0, 8'h00, "cfg");
		feat(8'hD0, 8'h00, "die");
		feat(8'hC0, 8'h00, "status");
		exe(8'h10, 24'h000040, 1'b1, 1'b0, 8'h08);
		exe(8'hD8, 24'h01FFC0, 1'b1, 1'b0, 8'h0C);
		`CHK("locked", 0, n_we + n_ers)
		set(8'hA0, 8'h00);
		feat(8'hA0, 8'h00, "unlock");
		exe(8'hD8, 24'h000100, 1'b0, 1'b0, 8'h0C);
		`CHK("no latch", 0, n_ers)
		fr('{8'h06});
		set(8'hC0, 8'hFF);
		feat(8'hC0, 8'h0E, "latch");
		fr('{8'h04});
		feat(8'hC0, 8'h0C, "unlatch");
		fr('{8'h06});
		lfsr = step(lfsr);
		exe(8'hD8, {7'h0, lfsr[10:0], 6'h0}, 1'b0, 1'b1, 8'h08);
		`CHK("erases", 1, n_ers)
		`CHK("block", lfsr[10:0], blk)
		for (int p = 0; p < 2; p++) begin
			lfsr = step(lfsr);
			c = lfsr[10:0];
			load(p ? 8'h32 : 8'h02, c, 6);
			load(p ? 8'h34 : 8'h84, 2174, 4);
			load(8'h84, c + 9, 3);
			exe(8'h10, {7'h0, lfsr[21:11], 6'h3}, 1'b1, 1'b1, 8'h00);
			chk_cache();
		end
		set(8'hD0, 8'hFF);
		feat(8'hD0, 8'h40, "die");
		set(8'hA0, 8'hFF);
		feat(8'hA0, 8'hFE, "lock");
		set(8'hA0, 8'h80);
		wp_val = 1'b0;
		set(8'hA0, 8'h7C);
		feat(8'hA0, 8'h80, "guard");
		wp_val = 1'b1;
		set(8'hA0, 8'h7C);
		feat(8'hA0, 8'h7C, "lock");
		set(8'hB0, 8'hFF);
		feat(8'hB0, 8'hF2, "cfg");
		fr('{8'hFF});
		feat(8'hB0, 8'h30, "cfg");
		feat(8'hD0, 8'h40, "die");
		set(8'hA0, 8'h00);
		feat(8'hA0, 8'h7C, "frozen");
		give_verdict();
	end
endmodule : serial_nand_program_erase_features_tb_top
